// file: pkg/rtsw_pkg.sv
`default_nettype none
package rtsw_pkg;

    // Host register offsets
    localparam logic [15:0] RTSW_ADDR_PENDING = 16'h0006;
    localparam logic [15:0] RTSW_ADDR_SWBITS = 16'h0007;
    localparam logic [15:0] RTSW_ZERO16 = 16'h0000;

    // Pending interrupt flag positions
    localparam int RTSW_P_SERIAL = 7;
    localparam int RTSW_P_LB_A = 6;
    localparam int RTSW_P_LB_B = 5;
    localparam int RTSW_P_TT_MATCH = 4;
    localparam int RTSW_P_TT_ROLL = 3;
    localparam int RTSW_P_ADDR_PAR = 2;
    localparam int RTSW_P_ROM_CK = 1;
    localparam int RTSW_P_RAM_INIT = 0;
    localparam logic [7:0] RTSW_HW_IRQ_MASK = 8'h9f;
    localparam logic [7:0] RTSW_MSG_IRQ_MASK = 8'h60;
    localparam logic [7:0] RTSW_ALWAYS_EN = 8'h07;
    localparam logic [7:0] RTSW_PEND_RESET = 8'h00;

    // Status word bits register layout
    localparam int RTSW_S_ONCE_CLEAR = 15;
    localparam int RTSW_S_MSG_ERR = 10;
    localparam int RTSW_S_INSTRUMENTATION_FLAG = 9;
    localparam int RTSW_S_SVC_REQ = 8;
    localparam int RTSW_S_BCAST = 4;
    localparam int RTSW_S_BUSY = 3;
    localparam int RTSW_S_SUBSYS = 2;
    localparam int RTSW_S_DBC_ACC = 1;
    localparam int RTSW_S_TERM = 0;
    localparam int RTSW_S_ADDR_LSB = 11;
    localparam logic [5:0] RTSW_ADDR_LATCH_RESET = 6'h01;
    localparam logic [15:0] RTSW_SW_WRITABLE = 16'h830d;
    localparam logic [15:0] RTSW_SW_HOST_BITS = 16'h03ff;
    localparam logic [15:0] RTSW_SW_RESET = 16'h0000;

    // Time-tag limits
    localparam logic [15:0] RTSW_TT_MAX = 16'hffff;
    localparam logic [15:0] RTSW_TT_MIN = 16'h0000;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rtsw_host_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } rtsw_word_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
        logic busy;
        logic suppress_data;
        logic was_busy_flag;
    } rtsw_resp_t;

endpackage : rtsw_pkg
`default_nettype wire

// file: hdl/rtsw_sync.sv
`timescale 1ns/100ps
`default_nettype none
module rtsw_sync (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_async,
    output logic o_sync
);
    logic stage1;

    // Two-flop synchroniser; stage1 feeds only o_sync
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule : rtsw_sync
`default_nettype wire

// file: hdl/rtsw_loopback_cmp.sv
`timescale 1ns/100ps
`default_nettype none
module rtsw_loopback_cmp
    import rtsw_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire rtsw_word_t i_tx,
    input wire rtsw_word_t i_rx,
    output logic o_mismatch
);
    logic [15:0] sent_word;
    logic armed;

    // Holds last transmitted word until its echo is decoded
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sent_word <= RTSW_ZERO16;
            armed <= 1'b0;
        end else if (i_tx.valid) begin
            sent_word <= i_tx.word;
            armed <= 1'b1;
        end else if (i_rx.valid) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_mismatch <= 1'b0;
        end else begin
            o_mismatch <= armed && i_rx.valid && (i_rx.word != sent_word);
        end
    end
endmodule : rtsw_loopback_cmp
`default_nettype wire

// file: hdl/rtsw_regs.sv
// Function
// - Serial framing error sets bit 7, hardware interrupt
// - Loopback mismatch sets bit 6/5, message interrupt
// - Time-tag match sets bit 4
// - Time-tag wrap to zero sets bit 3
// - Even address parity sets bit 2 always
// - Parity fail blocks terminal operation
// - Boot checksum failure sets bit 1
// - RAM init mismatch sets bit 0
// - Every flag assertion writes a log entry
// - Status bits copied into outgoing status word
// - Bus control acceptance bit never asserted
// - Host bits persist until host write, bit 15 once-and-clear or reset
// - Bits 4 and 10 device driven, read zero
// - Bit 15 clears register after one normal response with any of bits 9-0 set
// - Status mode codes unaffected by clear
// - Bits 14-10 and 7-4 read zero
// - Bit 9 instrumentation, bit 8 service request
// - Bit 3 forces busy on normal responses; status mode uses last-sent bit 3
// - Descriptor busy bit also forces busy
// - Busy response suppresses data words
// - Busy message sets was-busy flag
// - Both resets clear status bits register
// - Reading pending flags clears them
// - Subsystem flag is register OR pin
// - Bit 0 drives terminal flag
`timescale 1ns/100ps
`default_nettype none
module rtsw_regs
    import rtsw_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_soft_reset,
    // Host register port
    input wire rtsw_host_req_t i_host,
    output logic [15:0] o_host_rdata,
    // Interrupt enables, low byte
    input wire logic [7:0] i_irq_enable,
    // Hardware event sources
    input wire logic i_serial_variant,
    input wire logic i_serial_host_frame_fail,
    input wire rtsw_word_t i_tx_word,
    input wire logic i_tx_bus_b,
    input wire rtsw_word_t i_rx_bus_a,
    input wire rtsw_word_t i_rx_bus_b,
    input wire logic i_timetag_tick,
    input wire logic [15:0] i_timetag,
    input wire logic [15:0] i_timetag_util,
    input wire logic i_addr_latch,
    input wire logic [4:0] i_term_addr,
    input wire logic i_term_addr_parity,
    input wire logic i_start_execute,
    input wire logic i_boot_rom_checksum_fail,
    input wire logic i_ram_init_mismatch,
    // Response assembly request
    input wire logic i_resp_req,
    input wire logic i_resp_status_mode,
    input wire logic i_resp_desc_busy,
    input wire logic i_broadcast_received_flag,
    input wire logic i_message_error_flag,
    input wire logic i_subsystem_flag_pin,
    // Outputs
    output logic o_hardware_irq_out,
    output logic o_message_irq_out,
    output logic o_log_valid,
    output logic [15:0] o_log_id,
    output logic o_rt_run,
    output logic o_term_addr_parity_fail,
    output rtsw_resp_t o_resp
);
    logic [7:0] pending;
    logic [7:0] next_pending;
    logic [7:0] events;
    logic [7:0] enabled;
    logic [15:0] status_word_bits;
    logic [15:0] next_status_word_bits;
    logic [15:0] last_sent_bits;
    logic [15:0] timetag_prev;
    logic [5:0] addr_latched;
    logic parity_fail;
    logic parity_fail_d;
    logic mismatch_a;
    logic mismatch_b;
    logic ssf_pin;
    logic rd_pending;
    logic wr_swbits;
    logic clear_once;
    logic resp_busy;
    logic [15:0] host_bits;
    logic [15:0] resp_word;
    rtsw_word_t tx_a;
    rtsw_word_t tx_b;

    rtsw_sync u_ssf_sync (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_async(i_subsystem_flag_pin),
        .o_sync(ssf_pin)
    );

    always_comb begin
        tx_a.valid = i_tx_word.valid && !i_tx_bus_b;
        tx_a.word = i_tx_word.word;
        tx_b.valid = i_tx_word.valid && i_tx_bus_b;
        tx_b.word = i_tx_word.word;
    end

    rtsw_loopback_cmp u_lb_a (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_tx(tx_a),
        .i_rx(i_rx_bus_a),
        .o_mismatch(mismatch_a)
    );

    rtsw_loopback_cmp u_lb_b (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_tx(tx_b),
        .i_rx(i_rx_bus_b),
        .o_mismatch(mismatch_b)
    );

    // Terminal address and parity latch
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            addr_latched <= RTSW_ADDR_LATCH_RESET;
        end else if (i_addr_latch) begin
            addr_latched <= {i_term_addr_parity, i_term_addr};
        end
    end

    assign parity_fail = ~^addr_latched;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            parity_fail_d <= 1'b0;
        end else begin
            parity_fail_d <= parity_fail;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_rt_run <= 1'b0;
            o_term_addr_parity_fail <= 1'b0;
        end else begin
            o_rt_run <= i_start_execute && !parity_fail;
            o_term_addr_parity_fail <= parity_fail;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            timetag_prev <= RTSW_TT_MIN;
        end else if (i_timetag_tick) begin
            timetag_prev <= i_timetag;
        end
    end

    // Event sources, one cycle each
    always_comb begin
        events = 8'h00;
        events[RTSW_P_SERIAL] = i_serial_variant && i_serial_host_frame_fail;
        events[RTSW_P_LB_A] = mismatch_a;
        events[RTSW_P_LB_B] = mismatch_b;
        events[RTSW_P_TT_MATCH] = i_timetag_tick && (i_timetag == i_timetag_util);
        events[RTSW_P_TT_ROLL] = i_timetag_tick && (timetag_prev == RTSW_TT_MAX)
                                 && (i_timetag == RTSW_TT_MIN);
        events[RTSW_P_ADDR_PAR] = parity_fail && !parity_fail_d;
        events[RTSW_P_ROM_CK] = i_boot_rom_checksum_fail;
        events[RTSW_P_RAM_INIT] = i_ram_init_mismatch;
        enabled = events & (i_irq_enable | RTSW_ALWAYS_EN);
    end

    // Host decode
    assign rd_pending = i_host.rd && (i_host.addr == RTSW_ADDR_PENDING);
    assign wr_swbits = i_host.wr && (i_host.addr == RTSW_ADDR_SWBITS);

    // New events win over the read clear
    always_comb begin
        next_pending = rd_pending ? RTSW_PEND_RESET : pending;
        next_pending = next_pending | enabled;
    end

    // Pending flags survive software reset
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pending <= RTSW_PEND_RESET;
        end else begin
            pending <= next_pending;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_hardware_irq_out <= 1'b0;
            o_message_irq_out <= 1'b0;
        end else begin
            o_hardware_irq_out <= |(next_pending & RTSW_HW_IRQ_MASK);
            o_message_irq_out <= |(next_pending & RTSW_MSG_IRQ_MASK);
        end
    end

    // Interrupt log entry per flag assertion
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_log_valid <= 1'b0;
            o_log_id <= RTSW_ZERO16;
        end else begin
            o_log_valid <= |enabled;
            o_log_id <= {8'h00, enabled};
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_host_rdata <= RTSW_ZERO16;
        end else if (rd_pending) begin
            o_host_rdata <= {8'h00, pending};
        end else if (i_host.rd && (i_host.addr == RTSW_ADDR_SWBITS)) begin
            o_host_rdata <= status_word_bits & RTSW_SW_WRITABLE;
        end else if (i_host.rd) begin
            o_host_rdata <= RTSW_ZERO16;
        end
    end

    // Bits used by this response
    always_comb begin
        host_bits = i_resp_status_mode ? last_sent_bits : status_word_bits;
        resp_busy = host_bits[RTSW_S_BUSY] || i_resp_desc_busy;
        resp_word = RTSW_ZERO16;
        resp_word[RTSW_S_ADDR_LSB +: 5] = addr_latched[4:0];
        resp_word[RTSW_S_MSG_ERR] = i_message_error_flag;
        resp_word[RTSW_S_INSTRUMENTATION_FLAG] = host_bits[RTSW_S_INSTRUMENTATION_FLAG];
        resp_word[RTSW_S_SVC_REQ] = host_bits[RTSW_S_SVC_REQ];
        resp_word[RTSW_S_BCAST] = i_broadcast_received_flag;
        resp_word[RTSW_S_BUSY] = resp_busy;
        resp_word[RTSW_S_SUBSYS] = host_bits[RTSW_S_SUBSYS] || ssf_pin;
        resp_word[RTSW_S_DBC_ACC] = 1'b0;
        resp_word[RTSW_S_TERM] = host_bits[RTSW_S_TERM];
        clear_once = i_resp_req && !i_resp_status_mode && status_word_bits[RTSW_S_ONCE_CLEAR]
                     && |(status_word_bits & RTSW_SW_HOST_BITS);
    end

    // Host write, then once-and-clear, then resets
    always_comb begin
        next_status_word_bits = status_word_bits;
        if (wr_swbits) begin
            next_status_word_bits = i_host.wdata & RTSW_SW_WRITABLE;
        end
        if (clear_once) begin
            next_status_word_bits = RTSW_SW_RESET;
        end
        if (i_soft_reset) begin
            next_status_word_bits = RTSW_SW_RESET;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            status_word_bits <= RTSW_SW_RESET;
        end else begin
            status_word_bits <= next_status_word_bits;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset || i_soft_reset) begin
            last_sent_bits <= RTSW_SW_RESET;
        end else if (i_resp_req && !i_resp_status_mode) begin
            last_sent_bits <= status_word_bits;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_resp <= '0;
        end else begin
            o_resp.valid <= i_resp_req;
            if (i_resp_req) begin
                o_resp.word <= resp_word;
                o_resp.busy <= resp_busy;
                o_resp.suppress_data <= resp_busy;
                o_resp.was_busy_flag <= resp_busy;
            end
        end
    end
endmodule : rtsw_regs
`default_nettype wire

// file: dv/rtsw_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module rtsw_regs_checker
    import rtsw_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_soft_reset,
    input wire rtsw_host_req_t i_host,
    input wire logic [15:0] o_host_rdata,
    input wire logic [7:0] i_irq_enable,
    input wire logic i_addr_latch,
    input wire logic [4:0] i_term_addr,
    input wire logic i_term_addr_parity,
    input wire logic i_boot_rom_checksum_fail,
    input wire logic i_ram_init_mismatch,
    input wire logic i_resp_req,
    input wire logic i_resp_desc_busy,
    input wire logic o_hardware_irq_out,
    input wire logic o_message_irq_out,
    input wire logic o_log_valid,
    input wire logic [15:0] o_log_id,
    input wire logic o_rt_run,
    input wire logic o_term_addr_parity_fail,
    input wire rtsw_resp_t o_resp
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence rd_sw;
        i_host.rd && !i_host.wr && i_host.addr == RTSW_ADDR_SWBITS;
    endsequence
    sequence rd_pend;
        i_host.rd && i_host.addr == RTSW_ADDR_PENDING;
    endsequence
    chk_ram_init_flag: assert property (i_ram_init_mismatch |=> o_hardware_irq_out && o_log_valid && o_log_id[0])
        else $error("ram init flag missing");
    chk_rom_ck_flag: assert property (i_boot_rom_checksum_fail |=> o_hardware_irq_out && o_log_id[1])
        else $error("checksum flag missing");
    chk_resp_latency: assert property (i_resp_req |=> o_resp.valid)
        else $error("response late");
    chk_dbc_never: assert property (o_resp.valid |-> !o_resp.word[RTSW_S_DBC_ACC])
        else $error("bus control bit set");
    chk_busy_suppress: assert property (o_resp.valid && o_resp.busy |-> o_resp.suppress_data && o_resp.was_busy_flag)
        else $error("busy without suppress");
    chk_desc_busy: assert property (i_resp_req && i_resp_desc_busy |=> o_resp.busy && o_resp.word[RTSW_S_BUSY])
        else $error("descriptor busy lost");
    chk_ro_bits_zero: assert property (rd_sw |=> (o_host_rdata & ~RTSW_SW_WRITABLE) == 16'h0000)
        else $error("unused bits read set");
    chk_read_clears: assert property (i_irq_enable[6:5] == 2'b00 [*3] ##0 rd_pend |=> !o_message_irq_out)
        else $error("pending not cleared");
    chk_soft_reset: assert property (i_soft_reset ##1 !i_host.wr ##1 rd_sw |=> o_host_rdata == RTSW_SW_RESET)
        else $error("soft reset missed");
    chk_addr_parity: assert property (i_addr_latch && !(^{i_term_addr, i_term_addr_parity})
        |=> ##1 (o_term_addr_parity_fail && !o_rt_run))
        else $error("parity fail not held");
endmodule : rtsw_regs_checker
bind rtsw_regs rtsw_regs_checker u_chk (.*);
`default_nettype wire

// file: dv/rtsw_bus_echo.sv
`timescale 1ns/100ps
`default_nettype none
module rtsw_bus_echo
    import rtsw_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire rtsw_word_t i_tx,
    input wire logic i_tx_bus_b,
    input wire logic i_corrupt,
    output rtsw_word_t o_rx_a,
    output rtsw_word_t o_rx_b
);
    // Idle bus shows its own previous word inverted, so it toggles every idle cycle
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_rx_a <= '0;
            o_rx_b <= '0;
        end else begin
            o_rx_a <= '{i_tx.valid && !i_tx_bus_b, i_tx.valid && !i_tx_bus_b ? i_tx.word ^ {15'h0000, i_corrupt} : ~o_rx_a.word};
            o_rx_b <= '{i_tx.valid && i_tx_bus_b, i_tx.valid && i_tx_bus_b ? i_tx.word ^ {15'h0000, i_corrupt} : ~o_rx_b.word};
        end
    end
endmodule : rtsw_bus_echo
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import rtsw_pkg::*;
;
    logic i_clock = 1'b0, i_reset = 1'b1, corrupt = 1'b0;
    logic [6:0] ev = '0;
    wire i_ram_init_mismatch = ev[0], i_boot_rom_checksum_fail = ev[1], i_serial_host_frame_fail = ev[2];
    wire i_timetag_tick = ev[3], i_addr_latch = ev[4], i_resp_req = ev[5], i_soft_reset = ev[6];
    rtsw_host_req_t i_host = '0;
    logic [7:0] i_irq_enable = 8'h00;
    logic i_serial_variant = 1'b1, i_tx_bus_b = 1'b0, i_term_addr_parity = 1'b0, i_start_execute = 1'b1;
    logic i_resp_status_mode = 1'b0, i_resp_desc_busy = 1'b0, i_subsystem_flag_pin = 1'b0;
    logic i_broadcast_received_flag = 1'b1, i_message_error_flag = 1'b1;
    rtsw_word_t i_tx_word = '0, i_rx_bus_a, i_rx_bus_b;
    logic [15:0] i_timetag = 16'h0000, i_timetag_util = 16'h1234, o_host_rdata, o_log_id;
    logic [4:0] i_term_addr = 5'h01;
    logic o_hardware_irq_out, o_message_irq_out, o_log_valid, o_rt_run, o_term_addr_parity_fail;
    rtsw_resp_t o_resp;
    int n_fail = 0, samples_checked = 0;
    rtsw_regs u_dut (.*);
    rtsw_bus_echo u_echo (.i_clock(i_clock), .i_reset(i_reset), .i_tx(i_tx_word), .i_tx_bus_b(i_tx_bus_b),
        .i_corrupt(corrupt), .o_rx_a(i_rx_bus_a), .o_rx_b(i_rx_bus_b));
    initial begin
        forever #12.5 i_clock = ~i_clock;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic pulse(input int k);
        @(posedge i_clock) ev[k] <= 1'b1;
        @(posedge i_clock) ev <= '0;
        #1;
    endtask : pulse
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge i_clock) i_host <= '{1'b0, 1'b1, a, v};
        @(posedge i_clock) i_host <= '0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge i_clock) i_host <= '{1'b1, 1'b0, a, 16'h0000};
        @(posedge i_clock) i_host <= '0;
        #1 chk(o_host_rdata, e);
    endtask : rd
    task automatic resp(input logic m, input logic b, input logic [15:0] e);
        @(posedge i_clock) begin
            i_resp_status_mode <= m;
            i_resp_desc_busy <= b;
            ev[5] <= 1'b1;
        end
        @(posedge i_clock) ev <= '0;
        #1 chk(o_resp.word, e);
    endtask : resp
    task automatic tick(input logic [15:0] v);
        @(posedge i_clock) i_timetag <= v;
        pulse(3);
    endtask : tick
    task automatic tx(input logic b, input logic c);
        @(posedge i_clock) begin
            i_tx_word <= '{1'b1, 16'h5a5a};
            i_tx_bus_b <= b;
            corrupt <= c;
        end
        @(posedge i_clock) i_tx_word.valid <= 1'b0;
        repeat (3) @(posedge i_clock);
        #1;
    endtask : tx
    task automatic t_always_on;
        rd(RTSW_ADDR_SWBITS, 16'h0000);
        pulse(0);
        pulse(1);
        chk(o_hardware_irq_out, 1);
        rd(RTSW_ADDR_PENDING, 16'h0003);
        rd(RTSW_ADDR_PENDING, 16'h0000);
        chk(o_hardware_irq_out, 0);
    endtask : t_always_on
    task automatic t_hw_events;
        pulse(2);
        tick(16'h1234);
        rd(RTSW_ADDR_PENDING, 16'h0000);
        @(posedge i_clock) begin
            i_irq_enable <= 8'h98;
            i_serial_variant <= 1'b0;
        end
        pulse(2);
        chk(o_log_valid, 0);
        @(posedge i_clock) i_serial_variant <= 1'b1;
        pulse(2);
        chk(o_log_id, 16'h0080);
        chk(o_hardware_irq_out, 1);
        tick(16'h1234);
        tick(16'hffff);
        tick(16'h0000);
        rd(RTSW_ADDR_PENDING, 16'h0098);
    endtask : t_hw_events
    task automatic t_loopback;
        @(posedge i_clock) i_irq_enable <= 8'h60;
        tx(1'b0, 1'b1);
        chk(o_message_irq_out, 1);
        rd(RTSW_ADDR_PENDING, 16'h0040);
        tx(1'b1, 1'b1);
        rd(RTSW_ADDR_PENDING, 16'h0020);
        tx(1'b0, 1'b0);
        tx(1'b1, 1'b0);
        rd(RTSW_ADDR_PENDING, 16'h0000);
    endtask : t_loopback
    task automatic t_parity;
        @(posedge i_clock) i_term_addr <= 5'h03;
        pulse(4);
        @(posedge i_clock) #1;
        chk({o_rt_run, o_term_addr_parity_fail}, 2'b01);
        rd(RTSW_ADDR_PENDING, 16'h0004);
        @(posedge i_clock) {i_term_addr, i_term_addr_parity} <= 6'h0b;
        pulse(4);
        @(posedge i_clock) #1;
        chk(o_rt_run, 1);
    endtask : t_parity
    task automatic t_status_bits;
        wr(RTSW_ADDR_SWBITS, 16'hffff);
        rd(RTSW_ADDR_SWBITS, 16'h830d);
        wr(RTSW_ADDR_SWBITS, 16'h0301);
        resp(1'b0, 1'b0, 16'h2f11);
        resp(1'b0, 1'b0, 16'h2f11);
        wr(RTSW_ADDR_SWBITS, 16'h8200);
        resp(1'b0, 1'b0, 16'h2e10);
        rd(RTSW_ADDR_SWBITS, 16'h0000);
        resp(1'b1, 1'b0, 16'h2e10);
        resp(1'b0, 1'b0, 16'h2c10);
        @(posedge i_clock) {i_broadcast_received_flag, i_message_error_flag} <= 2'b00;
        resp(1'b0, 1'b0, 16'h2800);
        @(posedge i_clock) {i_broadcast_received_flag, i_message_error_flag} <= 2'b11;
    endtask : t_status_bits
    task automatic t_busy_subsys;
        wr(RTSW_ADDR_SWBITS, 16'h0008);
        resp(1'b0, 1'b0, 16'h2c18);
        chk({o_resp.busy, o_resp.suppress_data, o_resp.was_busy_flag}, 3'h7);
        wr(RTSW_ADDR_SWBITS, 16'h0004);
        resp(1'b0, 1'b1, 16'h2c1c);
        @(posedge i_clock) i_subsystem_flag_pin <= 1'b1;
        wr(RTSW_ADDR_SWBITS, 16'h0000);
        repeat (3) @(posedge i_clock);
        resp(1'b0, 1'b0, 16'h2c14);
        chk(o_resp.busy, 0);
        wr(RTSW_ADDR_SWBITS, 16'h0301);
        pulse(6);
        rd(RTSW_ADDR_SWBITS, 16'h0000);
    endtask : t_busy_subsys
    task automatic end_of_test;
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5000) @(posedge i_clock);
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge i_clock);
        i_reset <= 1'b0;
        t_always_on();
        t_hw_events();
        t_loopback();
        t_parity();
        t_status_bits();
        t_busy_subsys();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
